// ===== common/jtp_pkg.sv
// Overview of operation
// - mode picks the pattern; lane count and rate still follow link mode.
// - pseudo-random modes skip transport and link layers, raw bits out.
// - 7-bit uses taps 6 and 7, 9-bit uses taps 5 and 9.
// - longer modes use taps 14/15, 18/23 and 28/31.
// - each lane starts its pseudo-random sequence at its own phase.
// - clock mode repeats eight ones then eight zeros, raw, on every lane.
// - ramp replaces formatter data; link layer encodes and scrambles it.
// - ramp starts after alignment (8b/10b) or serializer init (64b/66b).
// - every lane ramps 0x00 to 0xff and wraps, both encodings.
// - transport patterns are the same for both encodings.
// - 8-bit modes: lane k sends k then 0xff minus k, alternating octets.
// - only lowest enabled lanes transmit transport patterns; rest dropped.
// - 16-bit modes with control bits use the long transport pattern.
// - long pattern lasts K times ceil((M*S+2)/K) frames.
// - frame 0: every sample equals its converter index plus one.
// - frame 1: every sample equals its sample index plus one.
// - frame 2 onward: every sample holds only its top bit set.
// - frame i below M*S sets one control bit, sample i mod S of i/S.
// - long pattern same on both links, starts after alignment, repeats.
// - alternating-bit mode sends D21.5 characters, both encodings.
// - comma mode sends K28.5 characters, 8b/10b only.
package jtp_pkg;

   // ==========================================
   // modes
   typedef enum logic [3:0] {
      TM_NORMAL, TM_PRBS7, TM_PRBS9, TM_PRBS15, TM_PRBS23, TM_PRBS31,
      TM_CLOCK, TM_RAMP, TM_TRANSPORT, TM_D21_5, TM_K28_5
   } test_mode_t;

   localparam test_mode_t TEST_MODE_RESET = TM_NORMAL;

   // ==========================================
   // pattern constants
   localparam logic [7:0] CLK_PAT_HIGH = 8'hff;
   localparam logic [7:0] CLK_PAT_LOW  = 8'h00;
   localparam logic [7:0] RAMP_FIRST   = 8'h00;
   localparam logic [7:0] SHORT_TOP    = 8'hff;
   localparam logic [7:0] D21_5_OCTET  = 8'hb5;
   localparam logic [7:0] K28_5_OCTET  = 8'hbc;
   localparam int         LFSR_W       = 31;
   localparam int         P7_A  = 6;
   localparam int         P7_B  = 7;
   localparam int         P9_A  = 5;
   localparam int         P9_B  = 9;
   localparam int         P15_A = 14;
   localparam int         P15_B = 15;
   localparam int         P23_A = 18;
   localparam int         P23_B = 23;
   localparam int         P31_A = 28;
   localparam int         P31_B = 31;

   // ==========================================
   // carriers
   typedef struct packed {
      logic [7:0] data;
      logic       is_k;
      logic       raw;
   } lane_octet_t;

   typedef struct packed {
      logic [2:0] lanes_per_link;
      logic       enc_64b66b;
      logic       ctrl16;
   } link_mode_t;

   typedef struct packed {
      logic ilas_done;
      logic serdes_ready;
   } link_status_t;

endpackage

// ===== src/bypass_lane_gen.sv
`timescale 1ns/1ps
module bypass_lane_gen import jtp_pkg::*; #(
   parameter int LANE_ID = 0
) (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire test_mode_t mode,
   input  wire logic       restart,
   input  wire logic       advance,
   output logic [7:0]      octet
);
   // ==========================================
   // per-lane seed keeps lanes out of phase
   localparam logic [LFSR_W-1:0] SEED = LFSR_W'(LANE_ID + 1);

   initial begin
      if (LANE_ID < 0 || LANE_ID > 126) $error("lane id out of range");
   end

   logic [LFSR_W-1:0] hist;
   logic [LFSR_W-1:0] next_hist;
   logic              clk_phase;
   logic              next_clk_phase;
   logic [7:0]        bits;

   // ==========================================
   // eight bits per cycle, oldest first in msb
   always_comb begin
      logic [LFSR_W-1:0] h;
      int                ta;
      int                tb;
      h = hist;
      ta = P7_A;
      tb = P7_B;
      bits = '0;
      unique case (mode)
         TM_PRBS9:  begin ta = P9_A;  tb = P9_B;  end
         TM_PRBS15: begin ta = P15_A; tb = P15_B; end
         TM_PRBS23: begin ta = P23_A; tb = P23_B; end
         TM_PRBS31: begin ta = P31_A; tb = P31_B; end
         default:   begin ta = P7_A;  tb = P7_B;  end
      endcase
      for (int i = 0; i < 8; i++) begin
         bits[7-i] = h[ta-1] ^ h[tb-1];
         h = {h[LFSR_W-2:0], bits[7-i]};
      end
      next_hist = restart ? SEED : (advance ? h : hist);
      next_clk_phase = restart ? 1'b0 : (advance ? ~clk_phase : clk_phase);
      octet = (mode == TM_CLOCK) ? (clk_phase ? CLK_PAT_LOW : CLK_PAT_HIGH) : bits;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         hist      <= SEED;
         clk_phase <= 1'b0;
      end else begin
         hist      <= next_hist;
         clk_phase <= next_clk_phase;
      end
   end

endmodule // bypass_lane_gen

// ===== src/pattern_skid_buf.sv
`timescale 1ns/1ps
module pattern_skid_buf #(
   parameter int WIDTH = 8
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic             flush,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   output logic                  out_valid,
   output logic [WIDTH-1:0]      out_data,
   input  wire logic             out_ready
);
   initial begin
      if (WIDTH < 1) $error("width must be positive");
   end

   logic             skid_valid;
   logic [WIDTH-1:0] skid_data;
   logic             next_out_valid;
   logic [WIDTH-1:0] next_out_data;
   logic             next_skid_valid;
   logic [WIDTH-1:0] next_skid_data;

   // ==========================================
   // second entry catches the word in flight when the sink stalls
   always_comb begin
      next_out_valid  = out_valid;
      next_out_data   = out_data;
      next_skid_valid = skid_valid;
      next_skid_data  = skid_data;
      if (out_ready || !out_valid) begin
         if (skid_valid) begin
            next_out_valid  = 1'b1;
            next_out_data   = skid_data;
            next_skid_valid = 1'b0;
         end else begin
            next_out_valid = in_valid;
            next_out_data  = in_data;
         end
      end else if (in_valid && in_ready) begin
         next_skid_valid = 1'b1;
         next_skid_data  = in_data;
      end
      if (flush) begin
         next_out_valid  = 1'b0;
         next_skid_valid = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         out_valid  <= 1'b0;
         out_data   <= '0;
         skid_valid <= 1'b0;
         skid_data  <= '0;
         in_ready   <= 1'b1;
      end else begin
         out_valid  <= next_out_valid;
         out_data   <= next_out_data;
         skid_valid <= next_skid_valid;
         skid_data  <= next_skid_data;
         in_ready   <= ~next_skid_valid;
      end
   end

endmodule // pattern_skid_buf

// ===== src/jesd_test_pattern_gen.sv
`timescale 1ns/1ps
module jesd_test_pattern_gen import jtp_pkg::*; #(
   parameter int MAX_LANES  = 4,
   parameter int LONG_LANES = 2,
   parameter int M_CONV     = 2,
   parameter int S_SAMP     = 1,
   parameter int K_FRAMES   = 10,
   parameter int N_BITS     = 15,
   parameter int CS_BITS    = 1
) (
   input  wire logic                        core_clk,
   input  wire logic                        rst,
   input  wire test_mode_t                  test_pattern_select,
   input  wire link_mode_t                  link_mode_select,
   input  wire logic                        link_enable,
   input  wire link_status_t                link_status,
   output lane_octet_t [2*MAX_LANES-1:0]    lane_out,
   output logic                             lane_valid,
   input  wire logic                        lane_ready,
   output logic [2*MAX_LANES-1:0]           lane_powered,
   output logic                             pattern_active
);
   // ==========================================
   // derived sizes
   localparam int NL       = 2 * MAX_LANES;
   localparam int MS       = M_CONV * S_SAMP;
   localparam int LONG_OCT = (MS * 2) / LONG_LANES;
   localparam int LONG_LEN = K_FRAMES * ((MS + 2 + K_FRAMES - 1) / K_FRAMES);
   localparam int OCT_W    = $clog2(LONG_OCT + 1);
   localparam int FRM_W    = $clog2(LONG_LEN + 1);
   localparam int BUF_W    = NL * $bits(lane_octet_t);

   initial begin
      if (MAX_LANES < 1 || MAX_LANES > 7) $error("lane count unsupported");
      if (LONG_LANES < 1 || LONG_LANES > MAX_LANES) $error("bad long lanes");
      if ((MS * 2) % LONG_LANES != 0) $error("samples must fill lanes evenly");
      if (N_BITS + CS_BITS > 16) $error("sample wider than 16 bits");
      if (N_BITS < 1 || K_FRAMES < 1) $error("bad frame shape");
      if (MS % LONG_LANES != 0) $error("each lane must carry whole samples");
      if (CS_BITS > 1) $error("one control bit per sample supported");
   end

   typedef enum {ST_IDLE, ST_WAIT, ST_RUN} gen_state_t;

   // ==========================================
   // long pattern sample word, data msb-aligned, control bits below
   function automatic logic [15:0] long_word(input int g, input int fi);
      logic [15:0] d;
      logic [15:0] w;
      if (fi == 0) begin
         d = 16'(g / S_SAMP + 1);
      end else if (fi == 1) begin
         d = 16'(g % S_SAMP + 1);
      end else begin
         d = 16'(1 << (N_BITS - 1));
      end
      w = 16'(d << (16 - N_BITS));
      if (CS_BITS > 0 && fi < MS && fi == g) begin
         w[15-N_BITS] = 1'b1;
      end
      return w;
   endfunction

   // ==========================================
   // alignment event by encoding; 64b/66b has no lane alignment
   // sequence, so the serializers being up is the earliest start
   function automatic logic align_evt(input link_mode_t lm, input link_status_t ls);
      if (lm.enc_64b66b) begin
         return ls.serdes_ready;
      end
      return ls.ilas_done;
   endfunction

   // ==========================================
   // control state
   gen_state_t            state;
   gen_state_t            next_state;
   test_mode_t            mode;
   test_mode_t            next_mode;
   logic [OCT_W-1:0]      oct_cnt;
   logic [OCT_W-1:0]      next_oct_cnt;
   logic [FRM_W-1:0]      frm_cnt;
   logic [FRM_W-1:0]      next_frm_cnt;
   logic [7:0]            ramp;
   logic [7:0]            next_ramp;
   logic                  short_ph;
   logic                  next_short_ph;
   logic                  next_active;
   logic [NL-1:0]         next_powered;
   logic                  start_evt;
   logic                  restart;
   logic                  fire;
   logic                  buf_in_ready;
   lane_octet_t [NL-1:0]  gen_word;

   // ==========================================
   // start condition per mode
   always_comb begin
      unique case (mode)
         TM_RAMP: begin
            start_evt = align_evt(link_mode_select, link_status);
         end
         TM_TRANSPORT: begin
            start_evt = align_evt(link_mode_select, link_status);
         end
         TM_K28_5: begin
            // no K characters in 64b/66b, so this mode never starts there
            start_evt = ~link_mode_select.enc_64b66b;
         end
         TM_NORMAL: begin
            start_evt = 1'b0;
         end
         default: begin
            start_evt = 1'b1;
         end
      endcase
   end

   // the generator only moves when the buffer can take a word,
   // so a receiver stall neither drops nor repeats an octet
   assign restart = (state == ST_WAIT) && start_evt;
   assign fire    = (state == ST_RUN) && buf_in_ready;

   // ==========================================
   // control
   always_comb begin
      next_state    = state;
      next_mode     = mode;
      // mode is only taken while the link is down; a change
      // while it runs would tear a pattern mid-frame
      if (!link_enable) begin
         next_mode  = test_pattern_select;
         next_state = ST_IDLE;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (mode != TM_NORMAL) begin
                  next_state = ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (start_evt) begin
                  next_state = ST_RUN;
               end
            end
            ST_RUN: begin
               next_state = ST_RUN;
            end
         endcase
      end
      next_active = (next_state == ST_RUN);
      for (int l = 0; l < NL; l++) begin
         next_powered[l] = (3'(l % MAX_LANES) < link_mode_select.lanes_per_link);
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state          <= ST_IDLE;
         mode           <= TEST_MODE_RESET;
         pattern_active <= 1'b0;
         lane_powered   <= '0;
      end else begin
         state          <= next_state;
         mode           <= next_mode;
         pattern_active <= next_active;
         lane_powered   <= next_powered;
      end
   end

   // ==========================================
   // pattern position, back to word 0 at every start
   always_comb begin
      next_oct_cnt  = oct_cnt;
      next_frm_cnt  = frm_cnt;
      next_ramp     = ramp;
      next_short_ph = short_ph;
      if (restart) begin
         next_oct_cnt  = '0;
         next_frm_cnt  = '0;
         next_ramp     = RAMP_FIRST;
         next_short_ph = 1'b0;
      end else if (fire) begin
         next_ramp     = ramp + 8'h01;
         next_short_ph = ~short_ph;
         if (oct_cnt == OCT_W'(LONG_OCT - 1)) begin
            next_oct_cnt = '0;
            if (frm_cnt == FRM_W'(LONG_LEN - 1)) begin
               next_frm_cnt = '0;
            end else begin
               next_frm_cnt = frm_cnt + FRM_W'(1);
            end
         end else begin
            next_oct_cnt = oct_cnt + OCT_W'(1);
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         oct_cnt  <= '0;
         frm_cnt  <= '0;
         ramp     <= RAMP_FIRST;
         short_ph <= 1'b0;
      end else begin
         oct_cnt  <= next_oct_cnt;
         frm_cnt  <= next_frm_cnt;
         ramp     <= next_ramp;
         short_ph <= next_short_ph;
      end
   end

   // ==========================================
   // per-lane pattern select
   for (genvar l = 0; l < NL; l++) begin : g_lane
      localparam int KIDX = l % MAX_LANES;
      logic [7:0]   byp_oct;
      logic [15:0]  lw;
      lane_octet_t  o;

      bypass_lane_gen #(
         .LANE_ID (l)
      ) u_bypass (
         .core_clk (core_clk),
         .rst      (rst),
         .mode     (mode),
         .restart  (restart),
         .advance  (fire),
         .octet    (byp_oct)
      );

      // same index math on both links
      always_comb begin
         lw = long_word(int'(oct_cnt >> 1) * LONG_LANES + KIDX,
                        int'(frm_cnt));
         o = '0;
         unique case (mode)
            // raw words pass the encoder and scrambler untouched
            TM_PRBS7, TM_PRBS9, TM_PRBS15, TM_PRBS23, TM_PRBS31: begin
               o.data = byp_oct;
               o.raw  = 1'b1;
            end
            TM_CLOCK: begin
               o.data = byp_oct;
               o.raw  = 1'b1;
            end
            TM_RAMP: begin
               o.data = ramp;
            end
            TM_TRANSPORT: begin
               // same for 8b/10b and 64b/66b
               if (link_mode_select.ctrl16) begin
                  if (KIDX < LONG_LANES) begin
                     o.data = oct_cnt[0] ? lw[7:0] : lw[15:8];
                  end
               end else begin
                  o.data = short_ph ? SHORT_TOP - 8'(KIDX) : 8'(KIDX);
               end
            end
            TM_D21_5: begin
               o.data = D21_5_OCTET;
            end
            TM_K28_5: begin
               o.data = K28_5_OCTET;
               o.is_k = 1'b1;
            end
            TM_NORMAL: begin
               o = '0;
            end
            default: begin
               o = '0;
            end
         endcase
         if (!next_powered[l]) begin
            o = '0;
         end
      end

      assign gen_word[l] = o;
   end

   // ==========================================
   // output buffer; a sink stall holds the generator
   // so no octet is skipped in any pattern
   pattern_skid_buf #(
      .WIDTH (BUF_W)
   ) u_buf (
      .core_clk  (core_clk),
      .rst       (rst),
      .flush     (~link_enable),
      .in_valid  (fire),
      .in_data   (gen_word),
      .in_ready  (buf_in_ready),
      .out_valid (lane_valid),
      .out_data  (lane_out),
      .out_ready (lane_ready)
   );

endmodule // jesd_test_pattern_gen

// ===== verif/jesd_test_pattern_gen_sva.sv
`timescale 1ns/1ps
module jesd_test_pattern_gen_sva import jtp_pkg::*; #(
   parameter int MAX_LANES = 4
) (
   input wire logic                     core_clk,
   input wire logic                     rst,
   input wire test_mode_t               test_pattern_select,
   input wire link_mode_t               link_mode_select,
   input wire logic                     link_enable,
   input wire link_status_t             link_status,
   input wire lane_octet_t [2*MAX_LANES-1:0] lane_out,
   input wire logic                     lane_valid,
   input wire logic                     lane_ready,
   input wire logic [2*MAX_LANES-1:0]   lane_powered,
   input wire logic                     pattern_active
);
   // ==========================================
   // helper state
   test_mode_t             mode_q, next_mode_q;
   logic [2:0]             run_cnt, next_run_cnt;
   logic [2*MAX_LANES-1:0] pow_exp;
   logic                   steady, fire, unp_bad;
   assign steady = link_enable && run_cnt >= 3'h4;
   assign fire = lane_valid && lane_ready;
   always_comb begin
      next_mode_q = link_enable ? mode_q : test_pattern_select;
      next_run_cnt = !link_enable ? 3'h0 : run_cnt + 3'(run_cnt != 3'h7);
      unp_bad = 1'b0;
      for (int l = 0; l < 2*MAX_LANES; l++) begin
         pow_exp[l] = (l % MAX_LANES) < int'(link_mode_select.lanes_per_link);
         if (!lane_powered[l] && lane_out[l] != '0) unp_bad = 1'b1;
      end
   end
   always_ff @(posedge core_clk) begin
      mode_q <= rst ? TM_NORMAL : next_mode_q;
      run_cnt <= rst ? 3'h0 : next_run_cnt;
   end
   // ==========================================
   // properties
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   a_reset_quiet: assert property (disable iff (1'b0) rst |=> !lane_valid &&
      !pattern_active && lane_powered == '0 && lane_out == '0) else $error("reset state");
   a_power_map: assert property (1'b1 |=> lane_powered == $past(pow_exp))
      else $error("powered lanes");
   a_stall_hold: assert property (lane_valid && !lane_ready && link_enable |=>
      !link_enable || (lane_valid && $stable(lane_out))) else $error("stalled word");
   a_raw_bypass: assert property (steady && lane_valid |-> lane_out[0].raw ==
      (mode_q inside {TM_PRBS7, TM_PRBS9, TM_PRBS15, TM_PRBS23, TM_PRBS31, TM_CLOCK}))
      else $error("raw flag");
   a_prbs7_taps: assert property (steady && lane_valid && mode_q == TM_PRBS7 |->
      lane_out[0].data[0] == (lane_out[0].data[6] ^ lane_out[0].data[7])) else $error("prbs7");
   a_clock_alt: assert property (steady && fire && mode_q == TM_CLOCK |=> !lane_valid ||
      lane_out[0].data == ~$past(lane_out[0].data)) else $error("clock pattern");
   a_ramp_step: assert property (steady && fire && mode_q == TM_RAMP |=> !lane_valid ||
      lane_out[0].data == $past(lane_out[0].data) + 8'h01) else $error("ramp step");
   a_char_d21: assert property (steady && lane_valid && mode_q == TM_D21_5 |->
      {lane_out[0].data, lane_out[0].is_k} == {D21_5_OCTET, 1'b0}) else $error("d21.5");
   a_char_k28: assert property (steady && lane_valid && mode_q == TM_K28_5 |->
      {lane_out[0].data, lane_out[0].is_k} == {K28_5_OCTET, 1'b1}) else $error("k28.5");
   a_k28_wide_off: assert property (steady && mode_q == TM_K28_5 &&
      link_mode_select.enc_64b66b |-> !lane_valid && !pattern_active) else $error("k28.5 64b");
   a_unpowered_zero: assert property (lane_valid |-> !unp_bad)
      else $error("unpowered lane");
   a_normal_silent: assert property (steady && mode_q == TM_NORMAL |->
      !lane_valid && !pattern_active) else $error("normal mode words");
endmodule // jesd_test_pattern_gen_sva

bind jesd_test_pattern_gen jesd_test_pattern_gen_sva #(.MAX_LANES(MAX_LANES))
   i_jesd_test_pattern_gen_sva (.core_clk(core_clk), .rst(rst),
   .test_pattern_select(test_pattern_select), .link_mode_select(link_mode_select),
   .link_enable(link_enable), .link_status(link_status), .lane_out(lane_out),
   .lane_valid(lane_valid), .lane_ready(lane_ready), .lane_powered(lane_powered),
   .pattern_active(pattern_active));

// ===== verif/lane_sink.sv
`timescale 1ns/1ps
module lane_sink import jtp_pkg::*; (
   input  wire logic              core_clk,
   input  wire logic              slow,
   input  wire logic              lane_valid,
   input  wire lane_octet_t [7:0] lane_out,
   output logic                   lane_ready
);
   lane_octet_t [7:0] words[$];
   int                seed = 32'he797;
   initial lane_ready = 1'b1;
   // ready mostly low when slow, so the two-entry buffer really fills
   always @(negedge core_clk) lane_ready <= !slow || (($random(seed) & 3) == 0);
   // takes whatever comes first, no phase assumed
   always @(posedge core_clk) if (lane_valid && lane_ready) words.push_back(lane_out);
endmodule // lane_sink

// ===== verif/test_jesd_test_pattern_gen.sv
`timescale 1ns/1ps
module test_jesd_test_pattern_gen;
   import jtp_pkg::*;
   localparam int M = 2, S = 1, K = 10, N = 15;
   logic              core_clk, rst, link_enable, slow, lane_valid, lane_ready, pattern_active;
   test_mode_t        test_pattern_select;
   link_mode_t        link_mode_select;
   link_status_t      link_status;
   lane_octet_t [7:0] lane_out;
   logic [7:0]        lane_powered;
   int                bad_count, comparisons, seed, ln, diff;
   test_mode_t cm[10] = '{TM_CLOCK, TM_RAMP, TM_RAMP, TM_TRANSPORT, TM_TRANSPORT,
      TM_TRANSPORT, TM_TRANSPORT, TM_D21_5, TM_K28_5, TM_K28_5};
   logic en[10] = '{0, 0, 1, 0, 1, 0, 1, 1, 0, 1};
   logic ct[10] = '{0, 0, 0, 0, 0, 1, 1, 0, 0, 0};
   int   nn[10] = '{24, 300, 24, 24, 24, 24, 24, 8, 8, 0};
   int   ta[5] = '{6, 5, 14, 18, 28};
   int   tb[5] = '{7, 9, 15, 23, 31};

   jesd_test_pattern_gen #(.LONG_LANES(2), .M_CONV(M), .S_SAMP(S), .K_FRAMES(K),
      .N_BITS(N)) i_jesd_test_pattern_gen (.core_clk(core_clk), .rst(rst),
      .test_pattern_select(test_pattern_select), .link_mode_select(link_mode_select),
      .link_enable(link_enable), .link_status(link_status), .lane_out(lane_out),
      .lane_valid(lane_valid), .lane_ready(lane_ready), .lane_powered(lane_powered),
      .pattern_active(pattern_active));
   lane_sink i_lane_sink (.core_clk(core_clk), .slow(slow), .lane_valid(lane_valid),
      .lane_out(lane_out), .lane_ready(lane_ready));

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // ==========================================
   // checking
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // long layout holds only for the parameters above: one sample per lane per frame
   function automatic logic [9:0] exp_octet(test_mode_t m, int l, int w, int lanes, logic c);
      int          k, f, v;
      logic [15:0] s;
      k = l % 4;
      if (k >= lanes) return 10'h0;
      if (m == TM_CLOCK) return {w[0] ? CLK_PAT_LOW : CLK_PAT_HIGH, 2'b01};
      if (m == TM_RAMP) return {w[7:0], 2'b00};
      if (m == TM_D21_5) return {D21_5_OCTET, 2'b00};
      if (m == TM_K28_5) return {K28_5_OCTET, 2'b10};
      if (!c) return {w[0] ? 8'hff - 8'(k) : 8'(k), 2'b00};
      f = (w / 2) % (K * ((M * S + 1 + K) / K));
      v = f == 0 ? k + 1 : (f == 1 ? 1 : 1 << (N - 1));
      s = 16'(v << (16 - N)) | 16'(int'(f == k && f < M * S) << (15 - N));
      return {w[0] ? s[7:0] : s[15:8], 2'b00};
   endfunction

   function automatic logic pbit(int l, int i);
      return i_lane_sink.words[i / 8][l].data[7 - i % 8];
   endfunction

   // ==========================================
   // one run of a mode
   task automatic run(test_mode_t m, int lanes, logic enc, logic c, int n);
      int t;
      @(negedge core_clk);
      link_enable = 1'b0;
      test_pattern_select = m;
      link_mode_select = '{3'(lanes), enc, c};
      link_status = 2'b00;
      repeat (3) @(negedge core_clk);
      i_lane_sink.words.delete();
      for (t = 0; t < 8; t++) check(lane_powered[t], (t % 4) < lanes);
      link_enable = 1'b1;
      @(negedge core_clk);
      // a change while running must be ignored
      test_pattern_select = test_mode_t'(4'($unsigned($random(seed)) % 11));
      if (m inside {TM_RAMP, TM_TRANSPORT}) begin
         link_status = enc ? 2'b10 : 2'b01;
         repeat (12) @(negedge core_clk);
         check(i_lane_sink.words.size(), 0);
         link_status = enc ? 2'b01 : 2'b10;
      end
      for (t = 0; t < (n == 0 ? 20 : 4000) && i_lane_sink.words.size() < (n == 0 ? 1 : n); t++)
         @(negedge core_clk);
      check(n == 0 ? i_lane_sink.words.size() : i_lane_sink.words.size() >= n, n != 0);
      check(pattern_active, n != 0);
   endtask

   // ==========================================
   // main sequence
   initial begin
      seed = 32'he797;
      rst = 1'b1;
      link_enable = 1'b0;
      slow = 1'b0;
      test_pattern_select = TM_NORMAL;
      link_mode_select = '0;
      link_status = '0;
      repeat (4) @(negedge core_clk);
      check({lane_valid, pattern_active, lane_powered}, 0);
      rst = 1'b0;
      run(TM_NORMAL, 4, 1'b0, 1'b0, 0);
      for (int p = 0; p < 5; p++) begin
         slow = p[0];
         run(test_mode_t'(p + 1), 4, 1'b0, 1'b0, 8);
         check(i_lane_sink.words[0][0].raw, 1);
         // the widest recursion keeps small seeds quiet for some bits
         diff = 0;
         for (int i = 0; i < 64; i++) diff += int'(pbit(0, i) != pbit(1, i));
         check(diff != 0, 1);
         for (int l = 0; l < 8; l += 5)
            for (int i = tb[p]; i < 64; i++)
               check(pbit(l, i), pbit(l, i - ta[p]) ^ pbit(l, i - tb[p]));
      end
      for (int c = 0; c < 10; c++) begin
         slow = c[0];
         ln = ct[c] ? 2 : 1 + $unsigned($random(seed)) % 4;
         run(cm[c], ln, en[c], ct[c], nn[c]);
         for (int w = 0; w < nn[c]; w++)
            for (int l = 0; l < 8; l++)
               check(i_lane_sink.words[w][l], exp_octet(cm[c], l, w, ln, ct[c]));
      end
      conclude();
   end

   // well beyond the slowest run, so a hang ends the test
   initial begin
      #240000;
      bad_count++;
      conclude();
   end
endmodule // test_jesd_test_pattern_gen
